// >>> hw/dbg_pkg.sv
package dbg_pkg;

    localparam int DATA_W = 8;

    // selector codes and the reset value of the selector
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] SEL_PART_ID = 8'h00;
    localparam logic [7:0] SEL_REVISION = 8'h01;
    localparam logic [7:0] SEL_HALT_CTRL = 8'h02;
    localparam logic [7:0] SEL_PROG_ENABLE = 8'hDF;
    localparam logic [7:0] SEL_MEM_DATA = 8'hBF;
    localparam logic [7:0] SEL_MEM_STATUS = 8'hB7;
    localparam logic [7:0] SEL_ADDR_HIGH = 8'hAF;
    localparam logic [7:0] SEL_ADDR_LOW = 8'hAE;
    localparam logic [7:0] SEL_CHECKSUM_0 = 8'hA9;
    localparam logic [7:0] SEL_CHECKSUM_1 = 8'hAA;
    localparam logic [7:0] SEL_CHECKSUM_2 = 8'hAB;
    localparam logic [7:0] SEL_CHECKSUM_3 = 8'hAC;

    // status byte returned by a selector read
    localparam int STATUS_BUSY_BIT = 7;
    localparam logic [6:0] STATUS_LOW_BITS = 7'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // link bit counts; opcode and input counts loaded as last index, output count as number of bits
    localparam logic [3:0] OPC_BITS_M1 = 4'h1;
    localparam logic [3:0] IN_BITS_M1 = 4'h7;
    localparam logic [3:0] OUT_BITS = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    typedef enum logic [1:0] {
        DBG_OP_DATA_RD = 2'b00,
        DBG_OP_DATA_WR = 2'b01,
        DBG_OP_ADDR_RD = 2'b10,
        DBG_OP_ADDR_WR = 2'b11
    } dbg_op_t;

    typedef enum logic [3:0] {
        DBG_TGT_NONE = 4'b0000,
        DBG_TGT_PART_ID = 4'b0001,
        DBG_TGT_REVISION = 4'b0010,
        DBG_TGT_HALT_CTRL = 4'b0011,
        DBG_TGT_PROG_ENABLE = 4'b0100,
        DBG_TGT_MEM_DATA = 4'b0101,
        DBG_TGT_MEM_STATUS = 4'b0110,
        DBG_TGT_ADDR_HIGH = 4'b0111,
        DBG_TGT_ADDR_LOW = 4'b1000,
        DBG_TGT_CHECKSUM_0 = 4'b1001,
        DBG_TGT_CHECKSUM_1 = 4'b1010,
        DBG_TGT_CHECKSUM_2 = 4'b1011,
        DBG_TGT_CHECKSUM_3 = 4'b1100
    } dbg_target_t;

    function automatic dbg_target_t dbg_route(input logic [7:0] sel);
        dbg_target_t t;
        case (sel)
            SEL_PART_ID: t = DBG_TGT_PART_ID;
            SEL_REVISION: t = DBG_TGT_REVISION;
            SEL_HALT_CTRL: t = DBG_TGT_HALT_CTRL;
            SEL_PROG_ENABLE: t = DBG_TGT_PROG_ENABLE;
            SEL_MEM_DATA: t = DBG_TGT_MEM_DATA;
            SEL_MEM_STATUS: t = DBG_TGT_MEM_STATUS;
            SEL_ADDR_HIGH: t = DBG_TGT_ADDR_HIGH;
            SEL_ADDR_LOW: t = DBG_TGT_ADDR_LOW;
            SEL_CHECKSUM_0: t = DBG_TGT_CHECKSUM_0;
            SEL_CHECKSUM_1: t = DBG_TGT_CHECKSUM_1;
            SEL_CHECKSUM_2: t = DBG_TGT_CHECKSUM_2;
            SEL_CHECKSUM_3: t = DBG_TGT_CHECKSUM_3;
            default: t = DBG_TGT_NONE;
        endcase
        return t;
    endfunction : dbg_route

    // identity registers and unmapped codes are answered locally
    function automatic logic dbg_needs_system(input dbg_target_t t);
        return !(t == DBG_TGT_NONE || t == DBG_TGT_PART_ID || t == DBG_TGT_REVISION);
    endfunction : dbg_needs_system

endpackage : dbg_pkg

// >>> hw/dbg_sync.sv
`timescale 1ns/1ps
module dbg_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i, // destination clock
    input wire logic reset_n_i, // async reset, active low
    input wire logic [WIDTH-1:0] async_i, // level from another domain
    output logic [WIDTH-1:0] sync_o // synchronised level
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } dbg_sync_s_t;

    dbg_sync_s_t s_q;
    dbg_sync_s_t s_d;

    if (WIDTH < 1) begin : g_chk
        $error("dbg_sync WIDTH must be at least 1");
    end

    // meta stage feeds only the second stage
    always_comb begin
        s_d.meta = async_i;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.sync;

endmodule : dbg_sync

// >>> hw/dbg_toggle_pulse.sv
`timescale 1ns/1ps
module dbg_toggle_pulse (
    input wire logic clk_i, // destination clock
    input wire logic reset_n_i, // async reset, active low
    input wire logic toggle_i, // event toggle from another domain
    output logic pulse_o // one cycle per toggle change
);
    typedef struct packed {
        logic last;
    } dbg_tp_s_t;

    dbg_tp_s_t s_q;
    dbg_tp_s_t s_d;
    logic tgl_s;

    dbg_sync #(
        .WIDTH(1)
    ) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i(toggle_i),
        .sync_o(tgl_s)
    );

    always_comb begin
        s_d.last = tgl_s;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pulse_o = tgl_s ^ s_q.last;

endmodule : dbg_toggle_pulse

// >>> hw/dbg_port.sv
`timescale 1ns/1ps
module dbg_port
    import dbg_pkg::*;
#(
    parameter logic [7:0] PART_ID_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] SILICON_REV_CODE = 8'h5A // arbitrary value
) (
    input wire logic sys_clk_i, // system clock, 25 MHz
    input wire logic reset_n_i, // async reset, active low
    input wire logic debug_clock_pin_i, // link clock from the adapter
    input wire logic debug_data_pin_i, // data line level as seen at the pin
    output logic debug_data_pin_o, // data line drive value
    output logic debug_data_pin_oe_o, // high while this end drives the line
    input wire logic mem_busy_i, // memory operation under way
    output dbg_pkg::dbg_target_t target_o, // register reached by the last forwarded request
    output logic wr_strobe_o, // one cycle, data write to target_o
    output logic [dbg_pkg::DATA_W-1:0] wr_data_o, // write byte, held until next write
    output logic rd_strobe_o, // one cycle, data read from target_o
    input wire logic [dbg_pkg::DATA_W-1:0] rd_data_i // read byte, valid while rd_strobe_o
);
    import dbg_pkg::*;

    typedef enum logic [2:0] {
        LNK_IDLE = 3'b000,
        LNK_OPC = 3'b001,
        LNK_IN = 3'b010,
        LNK_WAIT = 3'b011,
        LNK_OUT = 3'b100
    } dbg_link_st_t;

    // link domain state, clocked by the adapter
    typedef struct packed {
        dbg_link_st_t st;
        logic [3:0] cnt;
        logic [1:0] opc;
        logic [7:0] sh;
        logic [7:0] sel;
        logic pending;
        logic req_tgl;
        logic dout;
        logic doe;
    } dbg_link_s_t;

    // system domain state
    typedef struct packed {
        logic ack_tgl;
        logic wr_stb;
        logic rd_stb;
        logic cap;
        logic [7:0] wr_data;
        logic [7:0] rdata;
        dbg_target_t target;
    } dbg_sys_s_t;

    dbg_link_s_t ln_q;
    dbg_link_s_t ln_d;
    dbg_sys_s_t sy_q;
    dbg_sys_s_t sy_d;

    logic busy_s;
    logic req_pulse;
    logic ack_pulse;
    dbg_target_t cur_tgt;
    logic cur_sys;
    logic [7:0] byte_in;
    logic [1:0] opc_in;
    logic [7:0] local_rd;
    logic sys_rst_n;

    function automatic logic [7:0] dbg_local_read(input dbg_target_t t);
        logic [7:0] v;
        case (t)
            DBG_TGT_PART_ID: v = PART_ID_CODE;
            DBG_TGT_REVISION: v = SILICON_REV_CODE;
            default: v = UNMAPPED_READ;
        endcase
        return v;
    endfunction : dbg_local_read

    function automatic logic [3:0] dbg_count_down(input logic [3:0] c);
        return c - 4'h1;
    endfunction : dbg_count_down

    function automatic logic dbg_is_data_wr(input logic [1:0] op);
        return dbg_op_t'(op) == DBG_OP_DATA_WR;
    endfunction : dbg_is_data_wr

    // shifter, status byte and identity codes are all one byte wide
    if (DATA_W != 8) begin : g_width_chk
        $error("dbg_port serves only 8-bit data");
    end

    // reset release comes from a pin, so it is retimed to the system clock;
    // the link domain is released while its clock stands still
    dbg_sync #(
        .WIDTH(1)
    ) u_rst_sync (
        .clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(1'b1),
        .sync_o(sys_rst_n)
    );

    // busy comes from system logic, two flops into the link domain
    dbg_sync #(
        .WIDTH(1)
    ) u_busy_sync (
        .clk_i(debug_clock_pin_i),
        .reset_n_i(reset_n_i),
        .async_i(mem_busy_i),
        .sync_o(busy_s)
    );

    dbg_toggle_pulse u_req_cdc (
        .clk_i(sys_clk_i),
        .reset_n_i(sys_rst_n),
        .toggle_i(ln_q.req_tgl),
        .pulse_o(req_pulse)
    );

    dbg_toggle_pulse u_ack_cdc (
        .clk_i(debug_clock_pin_i),
        .reset_n_i(reset_n_i),
        .toggle_i(sy_q.ack_tgl),
        .pulse_o(ack_pulse)
    );

    // link engine; the data line is launched on the adapter clock, so it
    // is already in this domain and is sampled directly
    always_comb begin
        ln_d = ln_q;
        cur_tgt = dbg_route(ln_q.sel);
        cur_sys = dbg_needs_system(cur_tgt);
        byte_in = {ln_q.sh[6:0], debug_data_pin_i};
        opc_in = {ln_q.opc[0], debug_data_pin_i};
        local_rd = dbg_local_read(cur_tgt);
        case (ln_q.st)
            LNK_IDLE: begin
                ln_d.doe = 1'b0;
                if (!debug_data_pin_i) begin
                    ln_d.st = LNK_OPC;
                    ln_d.cnt = OPC_BITS_M1;
                end
            end
            LNK_OPC: begin
                ln_d.opc = opc_in;
                if (ln_q.cnt == CNT_ZERO) begin
                    case (dbg_op_t'(opc_in))
                        DBG_OP_ADDR_WR, DBG_OP_DATA_WR: begin
                            ln_d.st = LNK_IN;
                            ln_d.cnt = IN_BITS_M1;
                        end
                        DBG_OP_ADDR_RD: begin
                            // status, not the selector itself
                            // busy is two link edges old here; the adapter polls it
                            ln_d.sh = {busy_s, STATUS_LOW_BITS};
                            ln_d.pending = 1'b0;
                            ln_d.st = LNK_WAIT;
                        end
                        DBG_OP_DATA_RD: begin
                            ln_d.sh = local_rd;
                            ln_d.pending = cur_sys;
                            ln_d.req_tgl = ln_q.req_tgl ^ cur_sys;
                            ln_d.st = LNK_WAIT;
                        end
                        default: begin
                            ln_d.st = LNK_IDLE;
                        end
                    endcase
                end else begin
                    ln_d.cnt = dbg_count_down(ln_q.cnt);
                end
            end
            LNK_IN: begin
                ln_d.sh = byte_in;
                if (ln_q.cnt == CNT_ZERO) begin
                    if (dbg_op_t'(ln_q.opc) == DBG_OP_ADDR_WR) begin
                        ln_d.sel = byte_in;
                        ln_d.st = LNK_IDLE;
                    end else begin
                        // identity targets never reach system logic
                        ln_d.pending = cur_sys;
                        ln_d.req_tgl = ln_q.req_tgl ^ cur_sys;
                        ln_d.st = LNK_WAIT;
                    end
                end else begin
                    ln_d.cnt = dbg_count_down(ln_q.cnt);
                end
            end
            LNK_WAIT: begin
                // zeros while waiting, a one marks ready
                ln_d.doe = 1'b1;
                ln_d.dout = 1'b0;
                if (!ln_q.pending || ack_pulse) begin
                    ln_d.dout = 1'b1;
                    ln_d.pending = 1'b0;
                    ln_d.st = LNK_OUT;
                    if (dbg_is_data_wr(ln_q.opc)) begin
                        ln_d.cnt = CNT_ZERO;
                    end else begin
                        ln_d.cnt = OUT_BITS;
                    end
                    if (ln_q.pending && dbg_op_t'(ln_q.opc) == DBG_OP_DATA_RD) begin
                        // written by system side on the same edge that flips the ack toggle
                        ln_d.sh = sy_q.rdata;
                    end
                end
            end
            LNK_OUT: begin
                if (ln_q.cnt == CNT_ZERO) begin
                    ln_d.doe = 1'b0;
                    ln_d.st = LNK_IDLE;
                end else begin
                    ln_d.dout = ln_q.sh[7];
                    ln_d.sh = {ln_q.sh[6:0], 1'b0};
                    ln_d.cnt = dbg_count_down(ln_q.cnt);
                end
            end
            default: begin
                ln_d.doe = 1'b0;
                ln_d.st = LNK_IDLE;
            end
        endcase
    end

    always_ff @(posedge debug_clock_pin_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ln_q.st <= LNK_IDLE;
            ln_q.cnt <= CNT_ZERO;
            ln_q.opc <= 2'h0;
            ln_q.sh <= RESET_BYTE;
            ln_q.sel <= SEL_RESET;
            ln_q.pending <= 1'b0;
            ln_q.req_tgl <= 1'b0;
            ln_q.dout <= 1'b0;
            ln_q.doe <= 1'b0;
        end else begin
            ln_q <= ln_d;
        end
    end

    // system side; selector, opcode and write byte stay still while the
    // link waits for the ack, so reading them here after the toggle is safe
    always_comb begin
        sy_d = sy_q;
        sy_d.wr_stb = 1'b0;
        sy_d.rd_stb = 1'b0;
        sy_d.cap = 1'b0;
        if (sy_q.cap) begin
            sy_d.rdata = rd_data_i;
            sy_d.ack_tgl = ~sy_q.ack_tgl;
        end
        if (req_pulse) begin
            sy_d.target = dbg_route(ln_q.sel);
            if (dbg_is_data_wr(ln_q.opc)) begin
                sy_d.wr_stb = 1'b1;
                sy_d.wr_data = ln_q.sh;
                sy_d.ack_tgl = ~sy_q.ack_tgl;
            end else begin
                sy_d.rd_stb = 1'b1;
                sy_d.cap = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            sy_q.ack_tgl <= 1'b0;
            sy_q.wr_stb <= 1'b0;
            sy_q.rd_stb <= 1'b0;
            sy_q.cap <= 1'b0;
            sy_q.wr_data <= RESET_BYTE;
            sy_q.rdata <= RESET_BYTE;
            sy_q.target <= DBG_TGT_NONE;
        end else begin
            sy_q <= sy_d;
        end
    end

    assign debug_data_pin_o = ln_q.dout;
    assign debug_data_pin_oe_o = ln_q.doe;
    assign target_o = sy_q.target;
    assign wr_strobe_o = sy_q.wr_stb;
    assign wr_data_o = sy_q.wr_data;
    assign rd_strobe_o = sy_q.rd_stb;

endmodule : dbg_port

// >>> verification/dbg_port_assertions.sv
`timescale 1ns/1ps
module dbg_port_checker
    import dbg_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    input wire logic reset_n_i, // async reset, active low
    input wire logic debug_clock_pin_i, // link clock
    input wire logic debug_data_pin_oe_o, // device drives line
    input wire dbg_pkg::dbg_target_t target_o, // forwarded target
    input wire logic wr_strobe_o, // write pulse
    input wire logic [dbg_pkg::DATA_W-1:0] wr_data_o, // write byte
    input wire logic rd_strobe_o // read pulse
);
    sequence s_req;
        wr_strobe_o || rd_strobe_o;
    endsequence
    property p_wr_pulse;
        @(posedge sys_clk_i) disable iff (!reset_n_i) wr_strobe_o |=> !wr_strobe_o;
    endproperty
    property p_rd_pulse;
        @(posedge sys_clk_i) disable iff (!reset_n_i) rd_strobe_o |=> !rd_strobe_o;
    endproperty
    property p_one_kind;
        @(posedge sys_clk_i) disable iff (!reset_n_i) !(wr_strobe_o && rd_strobe_o);
    endproperty
    // identity and unmapped codes never reach the system side
    property p_local_kept;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
            s_req |-> !(target_o inside {DBG_TGT_NONE, DBG_TGT_PART_ID, DBG_TGT_REVISION});
    endproperty
    property p_wdata_hold;
        @(posedge sys_clk_i) disable iff (!reset_n_i) $changed(wr_data_o) |-> wr_strobe_o;
    endproperty
    property p_target_hold;
        @(posedge sys_clk_i) disable iff (!reset_n_i) $changed(target_o) |-> s_req;
    endproperty
    property p_reset_clean;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
            $rose(reset_n_i) |-> (target_o == DBG_TGT_NONE) && !wr_strobe_o && !rd_strobe_o;
    endproperty
    // an answer must hand the line back within a frame's length
    property p_oe_bounded;
        @(posedge debug_clock_pin_i) disable iff (!reset_n_i)
            $rose(debug_data_pin_oe_o) |-> ##[1:40] !debug_data_pin_oe_o;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    a_one_kind: assert property (p_one_kind) else $error("read and write together");
    a_local_kept: assert property (p_local_kept) else $error("local target forwarded");
    a_wdata_hold: assert property (p_wdata_hold) else $error("write byte moved");
    a_target_hold: assert property (p_target_hold) else $error("target moved");
    a_reset_clean: assert property (p_reset_clean) else $error("not clean after reset");
    a_oe_bounded: assert property (p_oe_bounded) else $error("line not released");
endmodule : dbg_port_checker

bind dbg_port dbg_port_checker u_dbg_port_checker (.sys_clk_i, .reset_n_i, .debug_clock_pin_i,
    .debug_data_pin_oe_o, .target_o, .wr_strobe_o, .wr_data_o, .rd_strobe_o);

// >>> verification/dbg_adapter.sv
`timescale 1ns/1ps
module dbg_adapter (
    output logic link_clk_o, // link clock, low between frames
    output logic drv_en_o, // adapter drives the line
    output logic drv_val_o, // adapter drive value
    input wire logic line_i // resolved data line
);
    initial begin
        link_clk_o = 1'b0;
        drv_en_o = 1'b0;
        drv_val_o = 1'b0;
    end
    // only the adapter makes the link clock
    task automatic tick(input logic en, input logic val, output logic smp);
        drv_en_o = en;
        drv_val_o = val;
        #7.5 link_clk_o = 1'b1;
        #7.0 smp = line_i;
        #0.5 link_clk_o = 1'b0;
    endtask : tick
    task automatic idle();
        logic s;
        tick(1'b0, 1'b0, s);
    endtask : idle
    task automatic frame(input logic [1:0] op, input logic [7:0] wb, output logic [7:0] rb, output logic rdy);
        logic s;
        int n;
        rb = 8'h00;
        rdy = 1'b1;
        tick(1'b1, 1'b0, s);
        tick(1'b1, op[1], s);
        tick(1'b1, op[0], s);
        if (op[0]) begin
            for (int i = 7; i >= 0; i--) begin
                tick(1'b1, wb[i], s);
            end
        end
        // first tick with the drive off hands the shared line over
        if (op != 2'b11) begin
            n = 0;
            s = 1'b0;
            while (!s && n < 40) begin
                tick(1'b0, 1'b0, s);
                n++;
            end
            rdy = s;
            if (!op[0]) begin
                for (int i = 7; i >= 0; i--) begin
                    tick(1'b0, 1'b0, s);
                    rb[i] = s;
                end
            end
            tick(1'b0, 1'b0, s);
        end else begin
            tick(1'b0, 1'b0, s);
        end
    endtask : frame
endmodule : dbg_adapter

// >>> verification/dbg_port_tb.sv
`timescale 1ns/1ps
module dbg_port_tb;
    import dbg_pkg::*;
    localparam logic [7:0] ID_C = 8'h3C; // arbitrary value
    localparam logic [7:0] REV_C = 8'h5A; // arbitrary value
    localparam logic [7:0] CODES [12] = '{8'h00, 8'h01, 8'h02, 8'hDF, 8'hBF, 8'hB7,
        8'hAF, 8'hAE, 8'hA9, 8'hAA, 8'hAB, 8'hAC};
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic mem_busy_i = 1'b0;
    logic [7:0] rd_data_i = 8'h00;
    logic link_clk, ad_en, ad_val, line, dev_val, dev_oe, wr_strobe, rd_strobe;
    logic [7:0] wr_data;
    logic [7:0] exp_w = 8'h00;
    logic [7:0] exp_wq[$];
    dbg_target_t target;
    dbg_target_t exp_t = DBG_TGT_NONE;
    int bad_count = 0;
    int n_checks = 0;
    int wr_n = 0;
    int rd_n = 0;
    int cyc = 0;
    assign line = dev_oe ? dev_val : (ad_en ? ad_val : 1'b1); // pull-up when released
    always #20 sys_clk_i = ~sys_clk_i;
    dbg_port #(.PART_ID_CODE(ID_C), .SILICON_REV_CODE(REV_C)) u_dbg_port (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .debug_clock_pin_i(link_clk), .debug_data_pin_i(line),
        .debug_data_pin_o(dev_val), .debug_data_pin_oe_o(dev_oe), .mem_busy_i(mem_busy_i),
        .target_o(target), .wr_strobe_o(wr_strobe), .wr_data_o(wr_data), .rd_strobe_o(rd_strobe),
        .rd_data_i(rd_data_i));
    dbg_adapter u_dbg_adapter (.link_clk_o(link_clk), .drv_en_o(ad_en), .drv_val_o(ad_val), .line_i(line));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    function automatic dbg_target_t exp_tgt(input logic [7:0] s);
        for (int i = 0; i < 12; i++) begin
            if (CODES[i] == s) begin
                return dbg_target_t'(i + 1);
            end
        end
        return DBG_TGT_NONE;
    endfunction : exp_tgt
    task automatic xfer(input logic [1:0] op, input logic [7:0] wb, input logic [7:0] er, input string nm);
        logic [7:0] rb;
        logic rdy;
        u_dbg_adapter.frame(op, wb, rb, rdy);
        chk({nm, " ready"}, {7'h00, rdy}, 8'h01);
        if (!op[0]) begin
            chk(nm, rb, er);
        end
        chk({nm, " release"}, {7'h00, dev_oe}, 8'h00);
    endtask : xfer
    // the system side: every forwarded request is compared with the model
    always @(negedge sys_clk_i) begin
        if (rd_strobe === 1'b1) begin
            rd_n++;
            chk("read target", 8'(target), 8'(exp_t));
        end
        if (wr_strobe === 1'b1) begin
            wr_n++;
            chk("write target", 8'(target), 8'(exp_t));
            if (exp_wq.size() == 0) begin
                chk("unexpected write", 8'h01, 8'h00);
            end else begin
                chk("write byte", wr_data, exp_wq.pop_front());
            end
        end
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        logic [7:0] sel;
        logic [7:0] er;
        logic loc;
        int n;
        void'($urandom(63341));
        repeat (12) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        u_dbg_adapter.idle();
        u_dbg_adapter.idle();
        xfer(2'b11, 8'hAE, 8'h00, "select");
        for (int b = 0; b < 2; b++) begin
            @(negedge sys_clk_i);
            mem_busy_i = b[0];
            repeat (2) @(negedge sys_clk_i);
            xfer(2'b10, 8'h00, {b[0], 7'h00}, "status");
        end
        for (int i = 0; i <= 12; i++) begin
            sel = (i < 12) ? CODES[i] : 8'h00;
            while (i == 12 && exp_tgt(sel) != DBG_TGT_NONE) begin
                sel = 8'($urandom);
            end
            xfer(2'b11, sel, 8'h00, "select");
            exp_t = exp_tgt(sel);
            exp_w = 8'($urandom);
            loc = exp_t inside {DBG_TGT_NONE, DBG_TGT_PART_ID, DBG_TGT_REVISION};
            if (!loc) begin
                exp_wq.push_back(exp_w);
            end
            n = wr_n;
            xfer(2'b01, exp_w, 8'h00, "data write");
            chk("write count", 8'(wr_n - n), loc ? 8'h00 : 8'h01);
            for (int k = 0; k < 2; k++) begin
                @(negedge sys_clk_i);
                rd_data_i = 8'($urandom);
                er = (exp_t == DBG_TGT_PART_ID) ? ID_C : (exp_t == DBG_TGT_REVISION) ? REV_C : rd_data_i;
                er = (exp_t == DBG_TGT_NONE) ? 8'h00 : er;
                n = rd_n;
                xfer(2'b00, 8'h00, er, "data read");
                chk("read count", 8'(rd_n - n), loc ? 8'h00 : 8'h01);
            end
        end
        @(negedge sys_clk_i);
        reset_n_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        u_dbg_adapter.idle();
        u_dbg_adapter.idle();
        exp_t = DBG_TGT_PART_ID;
        xfer(2'b00, 8'h00, ID_C, "read after reset");
        chk("writes left", 8'(exp_wq.size()), 8'h00);
        end_of_test();
    end
endmodule : dbg_port_tb
